/* File: src/fri_array.sv */
`default_nettype none
module fri_array (
  input  wire logic                         clk_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         wr_en_in,
  input  wire logic [fri_pkg::ADDR_W-1:0]   wr_addr_in,
  input  wire logic [fri_pkg::DATA_W-1:0]   wr_data_in,
  input  wire logic [fri_pkg::ADDR_W-1:0]   rd_addr_in,
  output logic      [fri_pkg::DATA_W-1:0]   rd_data_out
);
  // No reset on the array: the cells keep their contents like real storage.
  logic [fri_pkg::DATA_W-1:0] mem [fri_pkg::MEM_DEPTH];
  logic [fri_pkg::DATA_W-1:0] rd_q;

  always_ff @(posedge clk_in)
  begin
    if (clk_en_in)
    begin
      if (wr_en_in)
      begin
        mem[wr_addr_in] <= wr_data_in;
      end
      rd_q <= mem[rd_addr_in];
    end
  end

  assign rd_data_out = rd_q;
endmodule // fri_array
`default_nettype wire

/* File: src/fri_flash_bus.sv */
// Notes on behaviour
// - Written commands go to latches, not array.
// - Bad command sequence locks; reset command recovers.
// - Power-up and pin reset give asynchronous mode.
// - Strobe rising edge freezes the read address.
// - High bits pick page, low three pick word.
// - Output enable drives data only when selected.
// - Continuous and fixed-length linear bursts supported.
// - Burst mode only after configuration; then synchronous only.
// - Strobe low at clock edge latches burst start.
// - Strobe high and output enable low, each clock advances burst, ready high.
// - Burst data changes only at clock rising edge.
// - Ready low marks initial burst latency.
// - Reset pin ends burst, floats data and ready.
// - New strobe restarts burst at new address.
`default_nettype none
module fri_flash_bus (
  input  wire logic                         clk_in,
  input  wire logic                         sys_rst_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         chip_sel_n_in,
  input  wire logic                         out_en_n_in,
  input  wire logic                         write_en_n_in,
  input  wire logic                         address_valid_strobe_n_in,
  input  wire logic                         flash_clk_in,
  input  wire logic                         hw_reset_n_in,
  input  wire logic [fri_pkg::ADDR_W-1:0]   address_bus_in,
  input  wire logic [fri_pkg::DATA_W-1:0]   data_bus_in,
  output logic      [fri_pkg::DATA_W-1:0]   data_bus_out,
  output logic                              data_bus_oe_out,
  output logic                              ready_out,
  output logic                              ready_oe_out,
  output logic                              burst_mode_out,
  output logic                              cmd_fault_out,
  input  wire logic                         load_en_in,
  input  wire logic [fri_pkg::ADDR_W-1:0]   load_addr_in,
  input  wire logic [fri_pkg::DATA_W-1:0]   load_data_in
);
  logic                        fclk_q, fclk_d;
  logic                        avd_n_q, avd_n_d;
  logic                        we_n_q, we_n_d;
  logic [fri_pkg::ADDR_W-1:0]  lat_addr_q, lat_addr_d;
  logic [fri_pkg::ADDR_W-1:0]  cmd_addr_q, cmd_addr_d;
  logic [fri_pkg::DATA_W-1:0]  cmd_data_q, cmd_data_d;
  logic                        cmd_pend_q, cmd_pend_d;
  fri_pkg::fri_cmd_e           cmd_st_q, cmd_st_d;
  logic                        sync_mode_q, sync_mode_d;
  logic [fri_pkg::CFG_W-1:0]   cfg_q, cfg_d;
  fri_pkg::fri_bst_e           bst_q, bst_d;
  logic [fri_pkg::CNT_W-1:0]   wait_cnt_q, wait_cnt_d;
  logic [fri_pkg::ADDR_W-1:0]  burst_addr_q, burst_addr_d;
  logic [fri_pkg::DATA_W-1:0]  data_q, data_d;

  logic                        selected;
  logic                        fclk_rise;
  logic                        avd_rise;
  logic                        we_rise;
  logic                        burst_start;
  logic                        burst_step;
  logic [fri_pkg::ADDR_W-1:0]  async_addr;
  logic [fri_pkg::ADDR_W-fri_pkg::PAGE_LSB-1:0] page_select_bits;
  logic [2:0]                  page_word_select;
  logic [fri_pkg::ADDR_W-1:0]  read_addr;
  logic [fri_pkg::ADDR_W-1:0]  wrap_mask;
  logic [fri_pkg::ADDR_W-1:0]  addr_inc;
  logic [fri_pkg::DATA_W-1:0]  mem_rdata;

  // The pins are synchronous to clk_in, so edges are found by one-deep history.
  assign selected    = ~chip_sel_n_in & hw_reset_n_in;
  assign fclk_rise   = clk_en_in & flash_clk_in & ~fclk_q;
  assign avd_rise    = clk_en_in & address_valid_strobe_n_in & ~avd_n_q;
  assign we_rise     = clk_en_in & write_en_n_in & ~we_n_q & selected;
  assign burst_start = sync_mode_q & fclk_rise & selected & write_en_n_in
                       & ~address_valid_strobe_n_in;
  assign burst_step  = (bst_q == fri_pkg::BST_DATA) & fclk_rise & selected
                       & ~out_en_n_in & address_valid_strobe_n_in;

  always_comb
  begin
    fclk_d  = flash_clk_in;
    avd_n_d = address_valid_strobe_n_in;
    we_n_d  = write_en_n_in;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fclk_q  <= 1'b0;
      avd_n_q <= 1'b1;
      we_n_q  <= 1'b1;
    end
    else if (clk_en_in)
    begin
      fclk_q  <= fclk_d;
      avd_n_q <= avd_n_d;
      we_n_q  <= we_n_d;
    end
  end

  // While the strobe is low the address flows through; the host keeps it
  // steady during page reads, so no glitch filter is spent here. In the cycle of
  // the strobe's rising edge the bus is still used, as the latch fills only then.
  assign async_addr       = (address_valid_strobe_n_in & ~(avd_rise & selected))
                            ? lat_addr_q : address_bus_in;
  assign page_select_bits = async_addr[fri_pkg::ADDR_W-1:fri_pkg::PAGE_LSB];
  assign page_word_select = async_addr[fri_pkg::PAGE_LSB-1:0];
  assign read_addr        = {page_select_bits, page_word_select};

  always_comb
  begin
    lat_addr_d = lat_addr_q;
    if (avd_rise && selected)
    begin
      lat_addr_d = address_bus_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lat_addr_q <= fri_pkg::ADDR_RESET;
    end
    else if (clk_en_in)
    begin
      lat_addr_q <= lat_addr_d;
    end
  end

  // Command latches feed the command machine one cycle later.
  always_comb
  begin
    cmd_addr_d  = cmd_addr_q;
    cmd_data_d  = cmd_data_q;
    cmd_pend_d  = we_rise;
    cmd_st_d    = cmd_st_q;
    sync_mode_d = sync_mode_q;
    cfg_d       = cfg_q;
    if (we_rise)
    begin
      cmd_addr_d = async_addr;
      cmd_data_d = data_bus_in;
    end
    if (!hw_reset_n_in)
    begin
      cmd_st_d    = fri_pkg::CMD_IDLE;
      sync_mode_d = 1'b0;
    end
    else if (cmd_pend_q)
    begin
      if (cmd_data_q == fri_pkg::CMD_RESET)
      begin
        cmd_st_d    = fri_pkg::CMD_IDLE;
        sync_mode_d = 1'b0;
      end
      else
      begin
        case (cmd_st_q)
          fri_pkg::CMD_IDLE:
          begin
            if (cmd_data_q == fri_pkg::CMD_SET_CFG)
            begin
              cmd_st_d = fri_pkg::CMD_CFG_WAIT;
            end
            else
            begin
              cmd_st_d = fri_pkg::CMD_UNKNOWN;
            end
          end
          fri_pkg::CMD_CFG_WAIT:
          begin
            cfg_d       = cmd_data_q[fri_pkg::CFG_W-1:0];
            sync_mode_d = 1'b1;
            cmd_st_d    = fri_pkg::CMD_IDLE;
          end
          fri_pkg::CMD_UNKNOWN:
          begin
            cmd_st_d = fri_pkg::CMD_UNKNOWN;
          end
          default:
          begin
            cmd_st_d = fri_pkg::CMD_UNKNOWN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cmd_addr_q  <= fri_pkg::ADDR_RESET;
      cmd_data_q  <= fri_pkg::DATA_RESET;
      cmd_pend_q  <= 1'b0;
      cmd_st_q    <= fri_pkg::CMD_IDLE;
      sync_mode_q <= 1'b0;
      cfg_q       <= fri_pkg::CFG_RESET;
    end
    else if (clk_en_in)
    begin
      cmd_addr_q  <= cmd_addr_d;
      cmd_data_q  <= cmd_data_d;
      cmd_pend_q  <= cmd_pend_d;
      cmd_st_q    <= cmd_st_d;
      sync_mode_q <= sync_mode_d;
      cfg_q       <= cfg_d;
    end
  end

  // Linear bursts wrap inside an aligned block; continuous ones run on.
  always_comb
  begin
    case (cfg_q[fri_pkg::CFG_LEN_LSB+1:fri_pkg::CFG_LEN_LSB])
      fri_pkg::LEN_8:  wrap_mask = fri_pkg::MASK_8;
      fri_pkg::LEN_16: wrap_mask = fri_pkg::MASK_16;
      default:         wrap_mask = fri_pkg::MASK_32;
    endcase
    addr_inc = burst_addr_q + 10'h001;
    if (cfg_q[fri_pkg::CFG_LINEAR_BIT])
    begin
      addr_inc = (burst_addr_q & ~wrap_mask) | (addr_inc & wrap_mask);
    end
  end

  always_comb
  begin
    bst_d        = bst_q;
    wait_cnt_d   = wait_cnt_q;
    burst_addr_d = burst_addr_q;
    if (!selected || !sync_mode_q)
    begin
      bst_d = fri_pkg::BST_IDLE;
    end
    else if (burst_start)
    begin
      bst_d        = fri_pkg::BST_LAT;
      burst_addr_d = address_bus_in;
      wait_cnt_d   = cfg_q[fri_pkg::CFG_WAIT_LSB+fri_pkg::CNT_W-1:fri_pkg::CFG_WAIT_LSB];
    end
    else
    begin
      case (bst_q)
        fri_pkg::BST_IDLE:
        begin
          bst_d = fri_pkg::BST_IDLE;
        end
        fri_pkg::BST_LAT:
        begin
          if (fclk_rise)
          begin
            if (wait_cnt_q == fri_pkg::CNT_RESET)
            begin
              bst_d        = fri_pkg::BST_DATA;
              burst_addr_d = addr_inc;
            end
            else
            begin
              wait_cnt_d = wait_cnt_q - 4'h1;
            end
          end
        end
        fri_pkg::BST_DATA:
        begin
          if (burst_step)
          begin
            burst_addr_d = addr_inc;
          end
        end
        default:
        begin
          bst_d = fri_pkg::BST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bst_q        <= fri_pkg::BST_IDLE;
      wait_cnt_q   <= fri_pkg::CNT_RESET;
      burst_addr_q <= fri_pkg::ADDR_RESET;
    end
    else if (clk_en_in)
    begin
      bst_q        <= bst_d;
      wait_cnt_q   <= wait_cnt_d;
      burst_addr_q <= burst_addr_d;
    end
  end

  fri_array u_array (
    .clk_in      (clk_in),
    .clk_en_in   (clk_en_in),
    .wr_en_in    (load_en_in),
    .wr_addr_in  (load_addr_in),
    .wr_data_in  (load_data_in),
    .rd_addr_in  (sync_mode_q ? burst_addr_q : read_addr),
    .rd_data_out (mem_rdata)
  );

  // The array read is registered, so the word at the burst address is ready
  // long before the next device clock edge, which must be slower than clk_in.
  always_comb
  begin
    data_d = data_q;
    if (!sync_mode_q)
    begin
      data_d = mem_rdata;
    end
    else if ((bst_q == fri_pkg::BST_LAT && fclk_rise && selected && !burst_start
              && wait_cnt_q == fri_pkg::CNT_RESET) || (burst_step && !burst_start))
    begin
      data_d = mem_rdata;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_q <= fri_pkg::DATA_RESET;
    end
    else if (clk_en_in)
    begin
      data_q <= data_d;
    end
  end

  assign data_bus_out    = data_q;
  assign data_bus_oe_out = selected & ~out_en_n_in & write_en_n_in
                           & (~sync_mode_q | (bst_q == fri_pkg::BST_DATA));
  assign ready_oe_out    = selected;
  assign ready_out       = selected & (bst_q != fri_pkg::BST_LAT);
  assign burst_mode_out  = sync_mode_q;
  assign cmd_fault_out   = (cmd_st_q == fri_pkg::CMD_UNKNOWN);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_reset_cmd;
    we_rise && data_bus_in == fri_pkg::CMD_RESET && hw_reset_n_in && clk_en_in;
  endsequence
  sequence s_cmd_taken;
    clk_en_in;
  endsequence

  property p_standby;
    chip_sel_n_in |-> !data_bus_oe_out && !ready_oe_out;
  endproperty
  a_standby: assert property (p_standby) else $error("outputs driven in standby");

  property p_hw_reset;
    !hw_reset_n_in && clk_en_in |-> !data_bus_oe_out ##1 (bst_q == fri_pkg::BST_IDLE) && !sync_mode_q;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("pin reset did not end burst");

  property p_oe_gate;
    data_bus_oe_out |-> !chip_sel_n_in && !out_en_n_in;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("data driven without select and enable");

  property p_addr_latch;
    avd_rise && selected |=> lat_addr_q == $past(address_bus_in);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("strobe edge did not latch address");

  property p_cmd_latch;
    we_rise |=> cmd_data_q == $past(data_bus_in) && cmd_pend_q;
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not latched");

  property p_reset_cmd;
    s_reset_cmd ##1 s_cmd_taken |=> !sync_mode_q && cmd_st_q == fri_pkg::CMD_IDLE;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not recover");

  property p_sync_only;
    sync_mode_q && bst_q != fri_pkg::BST_DATA |-> !data_bus_oe_out;
  endproperty
  a_sync_only: assert property (p_sync_only) else $error("asynchronous read in burst mode");

  property p_start;
    burst_start && clk_en_in |=> bst_q == fri_pkg::BST_LAT && !ready_out
                                 && burst_addr_q == $past(address_bus_in);
  endproperty
  a_start: assert property (p_start) else $error("burst start not latched");

  property p_step;
    burst_step && !burst_start && !cfg_q[fri_pkg::CFG_LINEAR_BIT] && clk_en_in
      |=> burst_addr_q == $past(burst_addr_q) + 10'h001 && ready_out;
  endproperty
  a_step: assert property (p_step) else $error("burst did not advance");

  property p_data_edge;
    sync_mode_q && $past(sync_mode_q) && !$past(fclk_rise) |-> $stable(data_q);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("burst data changed off edge");

  property p_first_word;
    bst_q == fri_pkg::BST_LAT && wait_cnt_q == fri_pkg::CNT_RESET && fclk_rise
      && selected && sync_mode_q && !burst_start |=> bst_q == fri_pkg::BST_DATA && ready_out;
  endproperty
  a_first_word: assert property (p_first_word) else $error("latency end missed");
endmodule // fri_flash_bus
`default_nettype wire

/* File: src/fri_pkg.sv */
`default_nettype none
package fri_pkg;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 16;
  localparam int MEM_DEPTH = 1024;
  localparam int PAGE_LSB  = 3;
  localparam int CNT_W     = 4;
  localparam int CFG_W     = 7;

  localparam logic [DATA_W-1:0] CMD_RESET   = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_SET_CFG = 16'h00D0;

  localparam int CFG_WAIT_LSB   = 0;
  localparam int CFG_LINEAR_BIT = 4;
  localparam int CFG_LEN_LSB    = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

  localparam logic [1:0] LEN_8  = 2'h0;
  localparam logic [1:0] LEN_16 = 2'h1;
  localparam logic [ADDR_W-1:0] MASK_8  = 10'h007;
  localparam logic [ADDR_W-1:0] MASK_16 = 10'h00F;
  localparam logic [ADDR_W-1:0] MASK_32 = 10'h01F;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 4'h0;

  typedef enum logic [1:0] {CMD_IDLE, CMD_CFG_WAIT, CMD_UNKNOWN} fri_cmd_e;
  typedef enum logic [1:0] {BST_IDLE, BST_LAT, BST_DATA} fri_bst_e;
endpackage
`default_nettype wire

/* File: test/fri_host_model.sv */
`default_nettype none
module fri_host_model (
  input  wire logic                      clk_in,
  output var logic                       chip_sel_n_out,
  output var logic                       out_en_n_out,
  output var logic                       write_en_n_out,
  output var logic                       address_valid_strobe_n_out,
  output var logic                       flash_clk_out,
  output var logic [fri_pkg::ADDR_W-1:0] address_bus_out,
  output var logic [fri_pkg::DATA_W-1:0] data_bus_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    chip_sel_n_out             = 1'b1;
    out_en_n_out               = 1'b1;
    write_en_n_out             = 1'b1;
    address_valid_strobe_n_out = 1'b1;
    flash_clk_out              = 1'b0;
    address_bus_out            = 10'h000;
    data_bus_out               = 16'h0000;
  end

  task automatic sel(input logic cs_n, input logic oe_n);
    @(posedge clk_in) #1;
    chip_sel_n_out = cs_n;
    out_en_n_out   = oe_n;
    #1;
  endtask

  // The address moves only just after an edge; page reads change only its low bits.
  task automatic put_addr(input logic [fri_pkg::ADDR_W-1:0] a, input logic stb_n);
    @(posedge clk_in) #1;
    write_en_n_out             = 1'b1;
    address_bus_out            = a;
    address_valid_strobe_n_out = stb_n;
  endtask

  task automatic wr(input logic [fri_pkg::ADDR_W-1:0] a, input logic [fri_pkg::DATA_W-1:0] d);
    @(posedge clk_in) #1;
    chip_sel_n_out             = 1'b0;
    out_en_n_out               = 1'b1;
    write_en_n_out             = 1'b0;
    address_valid_strobe_n_out = 1'b0;
    address_bus_out            = a;
    data_bus_out               = d;
    @(posedge clk_in) #1;
    write_en_n_out = 1'b1;
    @(posedge clk_in) #1;
    chip_sel_n_out             = 1'b1;
    address_valid_strobe_n_out = 1'b1;
    // Released data lines show the inverse so a stale command is never seen again.
    data_bus_out               = ~d;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // One flash clock period; the clock stands low between calls, as it does outside bursts.
  task automatic fclk(input logic stb_n, input logic [fri_pkg::ADDR_W-1:0] a);
    @(posedge clk_in) #1;
    flash_clk_out              = 1'b1;
    address_valid_strobe_n_out = stb_n;
    address_bus_out            = a;
    repeat (2) @(posedge clk_in);
    #1;
    flash_clk_out              = 1'b0;
    address_valid_strobe_n_out = 1'b1;
    address_bus_out            = ~a;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
endmodule // fri_host_model
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in;
  logic        sys_rst_in;
  logic        hw_reset_n;
  logic        clk_en;
  logic        load_en;
  logic [9:0]  load_addr;
  logic [15:0] load_data;
  logic        cs_n;
  logic        oe_n;
  logic        we_n;
  logic        stb_n;
  logic        fclk;
  logic [9:0]  addr;
  logic [15:0] wdata;
  logic [15:0] data_out;
  logic        data_oe;
  logic        ready;
  logic        ready_oe;
  logic        burst_mode;
  logic        cmd_fault;
  int          errors;
  int          n_tests;
  int          cycles;

  fri_host_model i_fri_host_model (
    .clk_in                     (clk_in),
    .chip_sel_n_out             (cs_n),
    .out_en_n_out               (oe_n),
    .write_en_n_out             (we_n),
    .address_valid_strobe_n_out (stb_n),
    .flash_clk_out              (fclk),
    .address_bus_out            (addr),
    .data_bus_out               (wdata)
  );

  fri_flash_bus i_fri_flash_bus (
    .clk_in                    (clk_in),
    .sys_rst_in                (sys_rst_in),
    .clk_en_in                 (clk_en),
    .chip_sel_n_in             (cs_n),
    .out_en_n_in               (oe_n),
    .write_en_n_in             (we_n),
    .address_valid_strobe_n_in (stb_n),
    .flash_clk_in              (fclk),
    .hw_reset_n_in             (hw_reset_n),
    .address_bus_in            (addr),
    .data_bus_in               (wdata),
    .data_bus_out              (data_out),
    .data_bus_oe_out           (data_oe),
    .ready_out                 (ready),
    .ready_oe_out              (ready_oe),
    .burst_mode_out            (burst_mode),
    .cmd_fault_out             (cmd_fault),
    .load_en_in                (load_en),
    .load_addr_in              (load_addr),
    .load_data_in              (load_data)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [15:0] word(input logic [9:0] a);
    return {6'h2B, a};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [9:0] a);
    i_fri_host_model.sel(1'b0, 1'b0);
    i_fri_host_model.put_addr(a, 1'b0);
    i_fri_host_model.put_addr(a, 1'b1);
    i_fri_host_model.put_addr(~a, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    check(data_out, word(a));
    check({15'h0, data_oe}, 16'h0001);
  endtask

  // Wrap mask m selects continuous (all ones) or an aligned linear block.
  task automatic burst_run(input logic [9:0] a, input int wt, input logic [9:0] m, input int n);
    logic [9:0] ea;
    i_fri_host_model.sel(1'b0, 1'b0);
    i_fri_host_model.fclk(1'b0, a);
    check({15'h0, ready}, 16'h0000);
    check({15'h0, data_oe}, 16'h0000);
    for (int i = 1; i <= wt; i++)
    begin
      i_fri_host_model.fclk(1'b1, a);
      check({15'h0, ready}, 16'h0000);
    end
    for (int k = 0; k < n; k++)
    begin
      ea = (a & ~m) | ((a + k[9:0]) & m);
      i_fri_host_model.fclk(1'b1, a);
      check({15'h0, ready}, 16'h0001);
      check({15'h0, data_oe}, 16'h0001);
      check(data_out, word(ea));
    end
  endtask

  task automatic t_async();
    rd(10'h1A3);
    // A low clock enable must freeze the read path even though the address moves.
    @(posedge clk_in) #1;
    clk_en = 1'b0;
    i_fri_host_model.put_addr(10'h2C1, 1'b0);
    repeat (3) @(posedge clk_in);
    #1;
    check(data_out, word(10'h1A3));
    clk_en = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check(data_out, word(10'h2C1));
    i_fri_host_model.sel(1'b0, 1'b1);
    check({15'h0, data_oe}, 16'h0000);
    i_fri_host_model.sel(1'b1, 1'b0);
    check({14'h0, data_oe, ready_oe}, 16'h0000);
  endtask

  task automatic t_page();
    i_fri_host_model.sel(1'b0, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      i_fri_host_model.put_addr({7'h2C, k[2:0]}, 1'b0);
      repeat (3) @(posedge clk_in);
      #1;
      check(data_out, word({7'h2C, k[2:0]}));
    end
    i_fri_host_model.put_addr(10'h2C7, 1'b1);
  endtask

  task automatic t_cmd();
    i_fri_host_model.wr(10'h155, 16'h1234);
    check({15'h0, cmd_fault}, 16'h0001);
    i_fri_host_model.wr(10'h155, fri_pkg::CMD_SET_CFG);
    check({14'h0, burst_mode, cmd_fault}, 16'h0001);
    i_fri_host_model.wr(10'h155, fri_pkg::CMD_RESET);
    check({15'h0, cmd_fault}, 16'h0000);
    rd(10'h155);
  endtask

  task automatic t_burst_cont();
    i_fri_host_model.wr(10'h000, fri_pkg::CMD_SET_CFG);
    i_fri_host_model.wr(10'h000, 16'h0002);
    check({15'h0, burst_mode}, 16'h0001);
    i_fri_host_model.sel(1'b0, 1'b0);
    i_fri_host_model.put_addr(10'h055, 1'b0);
    i_fri_host_model.put_addr(10'h055, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    check({15'h0, data_oe}, 16'h0000);
    burst_run(10'h0FE, 2, 10'h3FF, 4);
    burst_run(10'h2F9, 2, 10'h3FF, 3);
    i_fri_host_model.sel(1'b1, 1'b0);
    check({14'h0, data_oe, ready_oe}, 16'h0000);
    i_fri_host_model.sel(1'b0, 1'b0);
    i_fri_host_model.fclk(1'b1, 10'h000);
    check({15'h0, data_oe}, 16'h0000);
  endtask

  task automatic t_burst_lin();
    i_fri_host_model.wr(10'h000, fri_pkg::CMD_SET_CFG);
    i_fri_host_model.wr(10'h000, 16'h0011);
    burst_run(10'h1F6, 1, fri_pkg::MASK_8, 4);
    // A rise with output enable high suspends the burst on the current word.
    i_fri_host_model.sel(1'b0, 1'b1);
    i_fri_host_model.fclk(1'b1, 10'h1F6);
    i_fri_host_model.sel(1'b0, 1'b0);
    check(data_out, word(10'h1F1));
    i_fri_host_model.fclk(1'b1, 10'h1F6);
    check(data_out, word(10'h1F2));
    @(posedge clk_in) #1;
    hw_reset_n = 1'b0;
    #1;
    check({14'h0, data_oe, ready_oe}, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    check({15'h0, burst_mode}, 16'h0000);
    hw_reset_n = 1'b1;
    rd(10'h3A7);
  endtask

  // The ceiling is about fifteen times the length of the planned sequence.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    errors     = 0;
    n_tests    = 0;
    cycles     = 0;
    sys_rst_in = 1'b1;
    hw_reset_n = 1'b1;
    clk_en     = 1'b1;
    load_en    = 1'b0;
    load_addr  = 10'h000;
    load_data  = 16'h0000;
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    check({14'h0, burst_mode, cmd_fault}, 16'h0000);
    check(data_out, 16'h0000);
    for (int i = 0; i < fri_pkg::MEM_DEPTH; i++)
    begin
      @(posedge clk_in) #1;
      load_en   = 1'b1;
      load_addr = i[9:0];
      load_data = word(i[9:0]);
    end
    @(posedge clk_in) #1;
    load_en = 1'b0;
    t_async();
    t_page();
    t_cmd();
    t_burst_cont();
    t_burst_lin();
    final_report();
  end
endmodule // tb
`default_nettype wire
